// File: hw/sec_cnt_regs.svh
// Purpose: offsets, field positions and reset values of the signed event counter bank
// Assumes: 32-bit avalon-mm data, word addressing by byte address / 4
// Notes: definitions only
`ifndef SEC_CNT_REGS_SVH
`define SEC_CNT_REGS_SVH

`define SEC_NUM_CNT 8
`define SEC_CNT_W 32
// nine 32-byte windows (globals plus eight banks) need a ninth address bit
`define SEC_ADDR_W 9
// global registers (byte offsets)
`define SEC_OFS_CTRL 9'h000
`define SEC_OFS_STAT 9'h004
`define SEC_OFS_IRQ_STAT 9'h008
`define SEC_OFS_IRQ_MASK 9'h00c
`define SEC_OFS_TIME_LO 9'h010
// per-counter bank: 9'h020 * (n + 1), five words
`define SEC_OFS_BANK 9'h020
`define SEC_BANK_SHIFT 5
`define SEC_OFS_PRESET 3'h0
`define SEC_OFS_COMPARE 3'h1
`define SEC_OFS_COUNT 3'h2
`define SEC_OFS_FROZEN 3'h3
`define SEC_OFS_STAMP 3'h4
// ctrl register bit: enable of counter n sits at bit n
`define SEC_RST_CTRL 8'h00
`define SEC_RST_WORD 32'h0000_0000
`define SEC_MAX_VAL 32'h7fff_ffff
`define SEC_MIN_VAL 32'h8000_0000
`define SEC_ONE 32'h0000_0001
`define SEC_STAMP_ONE 64'h0000_0000_0000_0001
`define SEC_UNMAPPED 32'hdead_beef

`endif

// File: hw/sec_pkg.sv
// Purpose: shared types of the signed event counter bank
// Assumes: used through sec_pkg::name only
// Notes: constants live in sec_cnt_regs.svh
package sec_pkg;
	// compare result of one counter
	typedef enum logic [1:0] {
		SEC_CMP_BELOW,
		SEC_CMP_EQUAL,
		SEC_CMP_ABOVE
	} sec_cmp_t;
	// bus slave phases
	typedef enum logic [1:0] {
		SEC_BUS_IDLE,
		SEC_BUS_ACK
	} sec_bus_t;
endpackage

// File: hw/sec_counter.sv
// Purpose: one signed up/down event counter with setpoint compare and freeze
// Assumes: all inputs except nrst synchronous to ref_clk; nrst asserts asynchronously
// Notes: one evaluation pass per clock
`timescale 1ns/1ps
`include "sec_cnt_regs.svh"
module sec_counter #(
	parameter int W = `SEC_CNT_W
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic enable_in,
	input wire logic up_in,
	input wire logic down_in,
	input wire logic block_in,
	input wire logic preset_select_input,
	input wire logic reset_in,
	input wire logic freeze_reset_in,
	input wire logic freeze_count_in,
	input wire logic [W-1:0] preset_val,
	input wire logic [W-1:0] compare_val,
	input wire logic [63:0] time_now,
	output logic [W-1:0] count_reg,
	output logic [W-1:0] frozen_reg,
	output logic [63:0] stamp_reg,
	output logic above_setpoint_flag,
	output logic equal_setpoint_flag,
	output logic below_setpoint_flag,
	output logic freeze_evt
);
	logic up_prev_reg;
	logic down_prev_reg;
	logic psel_prev_reg;
	logic en_prev_reg;
	logic up_edge;
	logic down_edge;
	logic freeze_any;
	logic [W-1:0] count_next;
	sec_pkg::sec_cmp_t cmp;

	// previous-pass copies for edge detection
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			up_prev_reg <= 1'b0;
			down_prev_reg <= 1'b0;
			psel_prev_reg <= 1'b0;
			en_prev_reg <= 1'b0;
		end else begin
			up_prev_reg <= up_in;
			down_prev_reg <= down_in;
			psel_prev_reg <= preset_select_input;
			en_prev_reg <= enable_in;
		end
	end

	// low-to-high only; falling edges are ignored
	assign up_edge = up_in && !up_prev_reg;
	assign down_edge = down_in && !down_prev_reg;
	assign freeze_any = freeze_reset_in || freeze_count_in;

	// count update, priority: enable edge, reset, freeze-reset, preset edge, counting
	always_comb begin
		count_next = count_reg;
		if (!enable_in) begin
			count_next = count_reg;
		end else if (!en_prev_reg || reset_in) begin
			count_next = preset_select_input ? preset_val : `SEC_RST_WORD;
		end else if (freeze_reset_in) begin
			count_next = `SEC_RST_WORD;
		end else if (preset_select_input && !psel_prev_reg) begin
			count_next = preset_val;
		end else if (!block_in && (up_edge != down_edge)) begin
			// both edges in one pass cancel; the wrap falls out of two's complement
			if (up_edge)
				count_next = count_reg + W'(`SEC_ONE);
			else
				count_next = count_reg - W'(`SEC_ONE);
		end
	end

	// accumulated value
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			count_reg <= `SEC_RST_WORD;
		else
			count_reg <= count_next;
	end

	// snapshot of the count before the freeze-reset clears it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			frozen_reg <= `SEC_RST_WORD;
			stamp_reg <= '0;
			freeze_evt <= 1'b0;
		end else begin
			freeze_evt <= enable_in && en_prev_reg && freeze_any;
			if (enable_in && en_prev_reg && freeze_any) begin
				frozen_reg <= count_reg;
				stamp_reg <= time_now;
			end
		end
	end

	// signed compare against the setpoint
	always_comb begin
		if ($signed(count_next) > $signed(compare_val))
			cmp = sec_pkg::SEC_CMP_ABOVE;
		else if (count_next == compare_val)
			cmp = sec_pkg::SEC_CMP_EQUAL;
		else
			cmp = sec_pkg::SEC_CMP_BELOW;
	end

	// flags registered; all dark while blocked or disabled
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			above_setpoint_flag <= 1'b0;
			equal_setpoint_flag <= 1'b0;
			below_setpoint_flag <= 1'b0;
		end else begin
			above_setpoint_flag <= enable_in && !block_in && (cmp == sec_pkg::SEC_CMP_ABOVE);
			equal_setpoint_flag <= enable_in && !block_in && (cmp == sec_pkg::SEC_CMP_EQUAL);
			below_setpoint_flag <= enable_in && !block_in && (cmp == sec_pkg::SEC_CMP_BELOW);
		end
	end
endmodule

// File: hw/sec_bank.sv
// Purpose: bank of eight signed event counters behind an avalon-mm slave
// Assumes: counter inputs come from logic on ref_clk; 20 MHz clock
// Notes: timestamp is a free-running tick counter, one tick per clock
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "sec_cnt_regs.svh"
module sec_bank #(
	parameter int N = `SEC_NUM_CNT,
	parameter int W = `SEC_CNT_W
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [`SEC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [N-1:0] up_in,
	input wire logic [N-1:0] down_in,
	input wire logic [N-1:0] block_in,
	input wire logic [N-1:0] preset_select_input,
	input wire logic [N-1:0] reset_in,
	input wire logic [N-1:0] freeze_reset_in,
	input wire logic [N-1:0] freeze_count_in,
	output logic [N-1:0] above_setpoint_flag,
	output logic [N-1:0] equal_setpoint_flag,
	output logic [N-1:0] below_setpoint_flag,
	output logic irq
);
	logic [N-1:0] enable_reg;
	logic [W-1:0] preset_reg [N];
	logic [W-1:0] compare_reg [N];
	logic [W-1:0] count_w [N];
	logic [W-1:0] frozen_w [N];
	logic [63:0] stamp_w [N];
	logic [63:0] time_reg;
	logic [N-1:0] freeze_evt;
	logic [N-1:0] irq_stat_reg;
	logic [N-1:0] irq_mask_reg;
	logic [N-1:0] abv_w;
	logic [N-1:0] eql_w;
	logic [N-1:0] blw_w;
	sec_pkg::sec_bus_t bus_reg;
	logic wr_go;
	logic rd_go;
	logic [31:0] rd_next;

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// counter index of a bank address
	function automatic int bank_idx(input logic [`SEC_ADDR_W-1:0] a);
		return int'(a >> `SEC_BANK_SHIFT) - 1;
	endfunction

	// word within a bank
	function automatic logic [2:0] bank_word(input logic [`SEC_ADDR_W-1:0] a);
		return a[4:2];
	endfunction

	// one cycle of waitrequest on every access; the answer comes the cycle after
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			bus_reg <= sec_pkg::SEC_BUS_IDLE;
		else if (bus_reg == sec_pkg::SEC_BUS_IDLE && (avs_read || avs_write))
			bus_reg <= sec_pkg::SEC_BUS_ACK;
		else
			bus_reg <= sec_pkg::SEC_BUS_IDLE;
	end

	assign wr_go = avs_write && bus_reg == sec_pkg::SEC_BUS_IDLE;
	assign rd_go = avs_read && bus_reg == sec_pkg::SEC_BUS_IDLE;

	// waitrequest high at rest, dropped in the ack cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !(rd_go || wr_go);
	end

	// read mux; unmapped addresses return a fixed marker
	always_comb begin
		int k;
		k = bank_idx(avs_address);
		rd_next = `SEC_UNMAPPED;
		case (avs_address)
			`SEC_OFS_CTRL: rd_next = 32'(enable_reg);
			`SEC_OFS_STAT: rd_next = 32'(irq_stat_reg & irq_mask_reg);
			`SEC_OFS_IRQ_STAT: rd_next = 32'(irq_stat_reg);
			`SEC_OFS_IRQ_MASK: rd_next = 32'(irq_mask_reg);
			`SEC_OFS_TIME_LO: rd_next = time_reg[31:0];
			default: begin
				if (k >= 0 && k < N) begin
					case (bank_word(avs_address))
						`SEC_OFS_PRESET: rd_next = preset_reg[k];
						`SEC_OFS_COMPARE: rd_next = compare_reg[k];
						`SEC_OFS_COUNT: rd_next = count_w[k];
						`SEC_OFS_FROZEN: rd_next = frozen_w[k];
						`SEC_OFS_STAMP: rd_next = stamp_w[k][31:0];
						default: rd_next = `SEC_UNMAPPED;
					endcase
				end
			end
		endcase
	end

	// read data register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			avs_readdata <= `SEC_RST_WORD;
		else if (rd_go)
			avs_readdata <= rd_next;
	end

	// software settings: enable, preset, compare, mask
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			enable_reg <= N'(`SEC_RST_CTRL);
			irq_mask_reg <= '0;
			for (int i = 0; i < N; i++) begin
				preset_reg[i] <= `SEC_RST_WORD;
				compare_reg[i] <= `SEC_RST_WORD;
			end
		end else if (wr_go) begin
			if (avs_address == `SEC_OFS_CTRL)
				enable_reg <= N'(be_merge(32'(enable_reg), avs_writedata, avs_byteenable));
			if (avs_address == `SEC_OFS_IRQ_MASK)
				irq_mask_reg <= N'(be_merge(32'(irq_mask_reg), avs_writedata, avs_byteenable));
			for (int i = 0; i < N; i++) begin
				if (bank_idx(avs_address) == i) begin
					if (bank_word(avs_address) == `SEC_OFS_PRESET)
						preset_reg[i] <= be_merge(preset_reg[i], avs_writedata, avs_byteenable);
					if (bank_word(avs_address) == `SEC_OFS_COMPARE)
						compare_reg[i] <= be_merge(compare_reg[i], avs_writedata, avs_byteenable);
				end
			end
		end
	end

	// sticky freeze events; a new event wins over a write-one clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			irq_stat_reg <= '0;
		else if (wr_go && avs_address == `SEC_OFS_IRQ_STAT && avs_byteenable[0])
			irq_stat_reg <= (irq_stat_reg & ~N'(avs_writedata)) | freeze_evt;
		else
			irq_stat_reg <= irq_stat_reg | freeze_evt;
	end

	// level interrupt
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_reg & irq_mask_reg);
	end

	// free-running stamp; wraps after a very long time
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			time_reg <= '0;
		else
			time_reg <= time_reg + `SEC_STAMP_ONE;
	end

	// eight identical counters
	for (genvar g = 0; g < N; g++) begin : g_cnt
		sec_counter #(
			.W(W)
		) u_cnt (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.enable_in(enable_reg[g]),
			.up_in(up_in[g]),
			.down_in(down_in[g]),
			.block_in(block_in[g]),
			.preset_select_input(preset_select_input[g]),
			.reset_in(reset_in[g]),
			.freeze_reset_in(freeze_reset_in[g]),
			.freeze_count_in(freeze_count_in[g]),
			.preset_val(preset_reg[g]),
			.compare_val(compare_reg[g]),
			.time_now(time_reg),
			.count_reg(count_w[g]),
			.frozen_reg(frozen_w[g]),
			.stamp_reg(stamp_w[g]),
			.above_setpoint_flag(abv_w[g]),
			.equal_setpoint_flag(eql_w[g]),
			.below_setpoint_flag(blw_w[g]),
			.freeze_evt(freeze_evt[g])
		);
	end

	// flags already come from flip-flops in each counter
	assign above_setpoint_flag = abv_w;
	assign equal_setpoint_flag = eql_w;
	assign below_setpoint_flag = blw_w;
endmodule

// File: testbench/sec_bank_monitor.sv
// Purpose: port-level checks of the counter bank and its bus slave
// Assumes: one clock domain, nrst asynchronous and active low
// Notes: bound to sec_bank from the bench top
`timescale 1ns/1ps
`include "sec_cnt_regs.svh"
module sec_bank_monitor #(
	parameter int N = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [N-1:0] block_in,
	input wire logic [N-1:0] above_setpoint_flag,
	input wire logic [N-1:0] equal_setpoint_flag,
	input wire logic [N-1:0] below_setpoint_flag,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire logic [N-1:0] hi = above_setpoint_flag;
	wire logic [N-1:0] eq = equal_setpoint_flag;
	wire logic [N-1:0] lo = below_setpoint_flag;
	// flag checks, per counter bit
	a_flag_onehot: assert property (((hi & eq) | (hi & lo) | (eq & lo)) == '0)
		else $error("two setpoint flags high");
	a_block_quiet: assert property (($past(block_in) & (hi | eq | lo)) == '0)
		else $error("flag high while blocked");
	a_reset_quiet: assert property ($rose(nrst) |-> (hi | eq | lo) == '0 && !irq)
		else $error("output high after reset");
	// bus slave timing: exactly one wait cycle per access
	a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low without request");
	a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low twice");
	a_read_answer: assert property ($rose(avs_read) |=> !avs_waitrequest)
		else $error("read not answered");
	a_write_answer: assert property ($rose(avs_write) |=> !avs_waitrequest)
		else $error("write not answered");
	a_hole_read: assert property ($rose(avs_read) && avs_address == 9'h014
		|=> avs_readdata == `SEC_UNMAPPED)
		else $error("unmapped read wrong");
	c_irq: cover property (irq);
	c_equal: cover property ($rose(eq[0]));
	c_block: cover property (block_in[0] ##1 block_in[0]);
endmodule

// File: testbench/sec_ops_model.sv
// Purpose: stand-in for the logic operands feeding the counter inputs
// Assumes: operands are levels on ref_clk, one value per pass
// Notes: drive() changes all levels just after an edge and holds a cycle
`timescale 1ns/1ps
module sec_ops_model (
	input wire logic ref_clk,
	output logic [7:0] up_in,
	output logic [7:0] down_in,
	output logic [7:0] block_in,
	output logic [7:0] preset_select_input,
	output logic [7:0] reset_in,
	output logic [7:0] freeze_reset_in,
	output logic [7:0] freeze_count_in
);
	// all operands low at power-up, like idle logic
	initial begin
		{up_in, down_in, block_in, preset_select_input} = '0;
		{reset_in, freeze_reset_in, freeze_count_in} = '0;
	end
	// one evaluation pass worth of operand levels
	task drive(input logic [7:0] u, d, b, p, r, fr, fc);
		@(posedge ref_clk);
		up_in <= u;
		down_in <= d;
		block_in <= b;
		preset_select_input <= p;
		reset_in <= r;
		freeze_reset_in <= fr;
		freeze_count_in <= fc;
	endtask
endmodule

// File: testbench/sec_bank_tb.sv
// Purpose: self-checking bench for the signed event counter bank
// Assumes: irq status bit n belongs to counter n
// Notes: counter 0 carries most scenarios, counter 1 shows independence
`timescale 1ns/1ps
`include "sec_cnt_regs.svh"
module sec_bank_tb;
	localparam logic [7:0] Z = 8'h00;
	logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
	logic [8:0] avs_address;
	logic [7:0] up_in, down_in, block_in, preset_select_input;
	logic [7:0] reset_in, freeze_reset_in, freeze_count_in;
	logic [7:0] above_setpoint_flag, equal_setpoint_flag, below_setpoint_flag;
	logic [31:0] avs_writedata, avs_readdata, rd, st;
	int num_errors = 0;
	int n_tests = 0;
	sec_bank #(.N(8), .W(32)) sec_bank_i (.ref_clk(ref_clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .up_in(up_in), .down_in(down_in),
		.block_in(block_in), .preset_select_input(preset_select_input), .reset_in(reset_in),
		.freeze_reset_in(freeze_reset_in), .freeze_count_in(freeze_count_in),
		.above_setpoint_flag(above_setpoint_flag), .equal_setpoint_flag(equal_setpoint_flag),
		.below_setpoint_flag(below_setpoint_flag), .irq(irq));
	sec_ops_model sec_ops_model_i (.ref_clk(ref_clk), .up_in(up_in), .down_in(down_in),
		.block_in(block_in), .preset_select_input(preset_select_input), .reset_in(reset_in),
		.freeze_reset_in(freeze_reset_in), .freeze_count_in(freeze_count_in));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task finish_test;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR %0t got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	// one avalon access; held until waitrequest is sampled low, bounded wait
	task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			$display("ERROR %0t bus access timed out", $time);
			num_errors++;
			finish_test;
		end
	endtask
	// short form for the low window; bank 7 is reached through bus() directly
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, {1'b0, a}, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, {1'b0, a}, 32'h0);
		chk(rd, e);
	endtask
	// flags of counter 0 as {above, equal, below}; negedge so updates have landed
	task flg(input logic [2:0] e);
		@(negedge ref_clk);
		chk({29'h0, above_setpoint_flag[0], equal_setpoint_flag[0], below_setpoint_flag[0]},
			{29'h0, e});
	endtask
	task pulse(input logic [7:0] u, d);
		sec_ops_model_i.drive(u, d, Z, Z, Z, Z, Z);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, Z);
	endtask
	task t_reset;
		rdc(8'h00, 32'h0);
		rdc(8'h28, 32'h0);
		rdc(8'h08, 32'h0);
		rdc(8'h14, `SEC_UNMAPPED);
		chk({31'h0, irq}, 32'h0);
		$display("t_reset done");
	endtask
	task t_enable;
		wr(8'h20, 32'h5);
		sec_ops_model_i.drive(Z, Z, Z, 8'h01, Z, Z, Z);
		wr(8'h00, 32'h1);
		rdc(8'h28, 32'h5);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, Z);
		rdc(8'h28, 32'h5);
		wr(8'h40, 32'h9);
		wr(8'h00, 32'h3);
		rdc(8'h48, 32'h0);
		// last counter sits above the 8-bit window
		bus(1'b1, 9'h100, 32'h3);
		sec_ops_model_i.drive(Z, Z, Z, 8'h80, Z, Z, Z);
		wr(8'h00, 32'h83);
		bus(1'b0, 9'h108, 32'h0);
		chk(rd, 32'h3);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, Z);
		$display("t_enable done");
	endtask
	task t_count;
		pulse(8'h01, Z);
		pulse(8'h01, Z);
		sec_ops_model_i.drive(8'h01, Z, Z, Z, Z, Z, Z);
		pulse(8'h01, Z);
		pulse(8'h01, 8'h01);
		pulse(Z, 8'h01);
		pulse(8'h02, Z);
		rdc(8'h28, 32'h7);
		rdc(8'h48, 32'h1);
		$display("t_count done");
	endtask
	task t_wrap;
		wr(8'h20, 32'h7fff_ffff);
		sec_ops_model_i.drive(Z, Z, Z, 8'h01, Z, Z, Z);
		rdc(8'h28, 32'h7fff_ffff);
		pulse(8'h01, Z);
		rdc(8'h28, 32'h8000_0000);
		pulse(Z, 8'h01);
		rdc(8'h28, 32'h7fff_ffff);
		sec_ops_model_i.drive(Z, Z, Z, Z, 8'h01, Z, Z);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, Z);
		rdc(8'h28, 32'h0);
		$display("t_wrap done");
	endtask
	// compare is signed, so all ones reads as minus one
	task t_compare;
		wr(8'h24, 32'h0);
		flg(3'h2);
		wr(8'h24, 32'hffff_ffff);
		flg(3'h4);
		wr(8'h24, 32'h1);
		flg(3'h1);
		sec_ops_model_i.drive(Z, Z, 8'h01, Z, Z, Z, Z);
		sec_ops_model_i.drive(8'h01, Z, 8'h01, Z, Z, Z, Z);
		sec_ops_model_i.drive(Z, Z, 8'h01, Z, Z, Z, Z);
		flg(3'h0);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, Z);
		rdc(8'h28, 32'h0);
		flg(3'h1);
		$display("t_compare done");
	endtask
	task t_freeze;
		pulse(8'h01, Z);
		pulse(8'h01, Z);
		wr(8'h0c, 32'h1);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, 8'h01, Z);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, Z);
		rdc(8'h28, 32'h0);
		rdc(8'h2c, 32'h2);
		// stamp must be a real tick count taken before now
		bus(1'b0, 9'h030, 32'h0);
		st = rd;
		bus(1'b0, 9'h010, 32'h0);
		n_tests++;
		if (st == 32'h0 || st >= rd) begin
			$display("ERROR %0t stamp not from the running time", $time);
			num_errors++;
		end
		rdc(8'h08, 32'h1);
		chk({31'h0, irq}, 32'h1);
		pulse(8'h01, Z);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, 8'h01);
		sec_ops_model_i.drive(Z, Z, Z, Z, Z, Z, Z);
		rdc(8'h28, 32'h1);
		rdc(8'h2c, 32'h1);
		wr(8'h0c, 32'h0);
		rdc(8'h08, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(8'h08, 32'h1);
		rdc(8'h08, 32'h0);
		$display("t_freeze done");
	endtask
	initial begin
		nrst = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 9'h000;
		avs_writedata = 32'h0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		t_reset;
		t_enable;
		t_count;
		t_wrap;
		t_compare;
		t_freeze;
		finish_test;
	end
endmodule
bind sec_bank sec_bank_monitor #(.N(N)) sec_bank_monitor_i (.ref_clk(ref_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .block_in(block_in),
	.above_setpoint_flag(above_setpoint_flag), .equal_setpoint_flag(equal_setpoint_flag),
	.below_setpoint_flag(below_setpoint_flag), .irq(irq));
